// ### rtl/pmw_defines.svh
// Constants for the PMBus secondary word and block engine.
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH

// =====================================================================
// Bus addressing
`define PMW_DEV_ADDR 7'h5a
`define PMW_RW_READ 1'b1
`define PMW_BITS_PER_BYTE 4'h8
`define PMW_IDLE_BYTE 8'hff

// =====================================================================
// Command byte positions within a write
`define PMW_IDX_CMD 8'h00
`define PMW_IDX_LO 8'h01
`define PMW_IDX_HI 8'h02

// =====================================================================
// Linear-11 field layout
`define PMW_EXP_MSB 15
`define PMW_EXP_LSB 11
`define PMW_MANT_MSB 10
`define PMW_EXP_W 5
`define PMW_MANT_W 11
`define PMW_VAL_W 48

`endif

// ### rtl/pmw_pkg.sv
// Types shared by the PMBus secondary engine.
`include "pmw_defines.svh"

package pmw_pkg;

  typedef enum logic [2:0] {
    LS_IDLE, LS_ADDR, LS_RX, LS_ACK, LS_LOAD, LS_TX, LS_TXACK, LS_SKIP
  } pmw_lstate_type;

  typedef struct packed {
    logic block;
    logic [15:0] word;
  } pmw_rsp_type;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] word;
    logic signed [`PMW_EXP_W-1:0] expo;
    logic signed [`PMW_MANT_W-1:0] mant;
    logic signed [`PMW_VAL_W-1:0] value;
  } pmw_wr_type;

endpackage : pmw_pkg

// ### rtl/pmw_lin11_decode.sv
// Linear-11 word decoder: exponent, mantissa and fixed-point value.
`timescale 1ns/1ps
`default_nettype none

`include "pmw_defines.svh"

module pmw_lin11_decode
  import pmw_pkg::*;
(
  input wire logic [15:0] word,
  output logic signed [`PMW_EXP_W-1:0] expo,
  output logic signed [`PMW_MANT_W-1:0] mant,
  output logic signed [`PMW_VAL_W-1:0] value
);

  logic [4:0] shiftAmt;

  // =====================================================================
  // Field split
  assign expo = word[`PMW_EXP_MSB:`PMW_EXP_LSB];
  assign mant = word[`PMW_MANT_MSB:0];

  // =====================================================================
  // Scaling
  // The value carries sixteen fraction bits, so exponents -16..15 map to
  // shifts 0..31 by flipping the sign bit; every exponent is accepted.
  assign shiftAmt = {~expo[4], expo[3:0]};
  assign value = `PMW_VAL_W'(mant) <<< shiftAmt;

endmodule : pmw_lin11_decode

`default_nettype wire

// ### rtl/pmw_secondary.sv
// PMBus secondary engine: word write, word read and block read.
//
// Contract
// - Upper five bits: signed exponent, scale factor.
// - Lower eleven bits: signed mantissa.
// - Value is mantissa times two to exponent.
// - Words travel low byte first, high second.
// - Decoder accepts every exponent value.
// - Device acknowledges own address and command.
// - Read uses repeated START; device acknowledges read.
// - Word read: two bytes, host NACKs second.
// - Block read opens with byte count.
`timescale 1ns/1ps
`default_nettype none

`include "pmw_defines.svh"

module pmw_secondary
  import pmw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic fetchReq,
  output logic [7:0] fetchIdx,
  input wire logic rspValid,
  input wire pmw_rsp_type rsp,
  output logic cmdStrobe,
  output logic [7:0] cmdCode,
  output logic wrStrobe,
  output pmw_wr_type wr
);

  typedef struct packed {
    logic rstS1, rstS2, sclS1, sclS2, sdaS1, sdaS2, ackS1, ackS2;
    logic sclP, sdaP, ackP, lowOut;
    pmw_lstate_type st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] rxIdx, txIdx, cmd, wrLo, count, reqIdx;
    logic [15:0] wrWord, txWord;
    logic isBlock, pend, reqTgl, cmdTgl, wrTgl, sdaOe, sclOe;
  } pmw_link_type;

  typedef struct packed {
    logic reqS1, reqS2, reqP, cmdS1, cmdS2, cmdP, wrS1, wrS2, wrP;
    logic waitRsp, ackTgl;
    pmw_rsp_type rspHeld;
    logic fetchReq;
    logic [7:0] fetchIdx;
    logic cmdStrobe;
    logic [7:0] cmdCode;
    logic wrStrobe;
    pmw_wr_type wr;
  } pmw_sys_type;

  pmw_link_type lnk_r, lnk_nxt;
  pmw_sys_type sys_r, sys_nxt;
  logic sclRise, sclFall, startSeen, stopSeen, ackEvt;
  logic [7:0] txByte;
  logic signed [`PMW_EXP_W-1:0] decExpo;
  logic signed [`PMW_MANT_W-1:0] decMant;
  logic signed [`PMW_VAL_W-1:0] decValue;

  // =====================================================================
  // Link-side events
  assign sclRise = lnk_r.sclS2 & ~lnk_r.sclP;
  assign sclFall = ~lnk_r.sclS2 & lnk_r.sclP;
  assign startSeen = lnk_r.sclS2 & lnk_r.sclP & lnk_r.sdaP & ~lnk_r.sdaS2;
  assign stopSeen = lnk_r.sclS2 & lnk_r.sclP & ~lnk_r.sdaP & lnk_r.sdaS2;
  assign ackEvt = lnk_r.ackS2 ^ lnk_r.ackP;

  // Bytes past the end of a word or block go out as all ones, which
  // leaves the data line released.
  always_comb begin
    if (lnk_r.isBlock) begin
      txByte = (lnk_r.txIdx <= lnk_r.count) ? lnk_r.txWord[7:0] : `PMW_IDLE_BYTE;
    end else if (lnk_r.txIdx == `PMW_IDX_CMD) begin
      txByte = lnk_r.txWord[7:0];
    end else if (lnk_r.txIdx == `PMW_IDX_LO) begin
      txByte = lnk_r.txWord[15:8];
    end else begin
      txByte = `PMW_IDLE_BYTE;
    end
  end

  // =====================================================================
  // Link-side state machine
  always_comb begin
    lnk_nxt = lnk_r;
    lnk_nxt.rstS1 = rst_n;
    lnk_nxt.rstS2 = lnk_r.rstS1;
    lnk_nxt.sclS1 = sclIn;
    lnk_nxt.sclS2 = lnk_r.sclS1;
    lnk_nxt.sdaS1 = sdaIn;
    lnk_nxt.sdaS2 = lnk_r.sdaS1;
    lnk_nxt.ackS1 = sys_r.ackTgl;
    lnk_nxt.ackS2 = lnk_r.ackS1;
    lnk_nxt.sclP = lnk_r.sclS2;
    lnk_nxt.sdaP = lnk_r.sdaS2;
    lnk_nxt.ackP = lnk_r.ackS2;
    if (!lnk_r.rstS2) begin
      lnk_nxt.sclP = 1'b1;
      lnk_nxt.sdaP = 1'b1;
      lnk_nxt.ackP = 1'b0;
      lnk_nxt.lowOut = 1'b0;
      lnk_nxt.st = LS_IDLE;
      lnk_nxt.bitCnt = 4'h0;
      lnk_nxt.shift = 8'h00;
      lnk_nxt.rw = 1'b0;
      lnk_nxt.rxIdx = 8'h00;
      lnk_nxt.txIdx = 8'h00;
      lnk_nxt.cmd = 8'h00;
      lnk_nxt.wrLo = 8'h00;
      lnk_nxt.count = 8'h00;
      lnk_nxt.reqIdx = 8'h00;
      lnk_nxt.wrWord = 16'h0000;
      lnk_nxt.txWord = 16'h0000;
      lnk_nxt.isBlock = 1'b0;
      lnk_nxt.pend = 1'b0;
      lnk_nxt.reqTgl = 1'b0;
      lnk_nxt.cmdTgl = 1'b0;
      lnk_nxt.wrTgl = 1'b0;
      lnk_nxt.sdaOe = 1'b0;
      lnk_nxt.sclOe = 1'b0;
    end else begin
      if (ackEvt) begin
        lnk_nxt.pend = 1'b0;
        lnk_nxt.txWord = sys_r.rspHeld.word;
        if (lnk_r.txIdx == `PMW_IDX_CMD) begin
          lnk_nxt.isBlock = sys_r.rspHeld.block;
          lnk_nxt.count = sys_r.rspHeld.word[7:0];
        end
      end
      if (startSeen) begin
        lnk_nxt.st = LS_ADDR;
        lnk_nxt.bitCnt = 4'h0;
        lnk_nxt.sdaOe = 1'b0;
        lnk_nxt.sclOe = 1'b0;
      end else if (stopSeen) begin
        lnk_nxt.st = LS_IDLE;
        lnk_nxt.sdaOe = 1'b0;
        lnk_nxt.sclOe = 1'b0;
      end else begin
        case (lnk_r.st)
          LS_ADDR, LS_RX: begin
            if (sclRise) begin
              lnk_nxt.shift = {lnk_r.shift[6:0], lnk_r.sdaS2};
              lnk_nxt.bitCnt = lnk_r.bitCnt + 4'h1;
            end else if (sclFall && lnk_r.bitCnt == `PMW_BITS_PER_BYTE) begin
              lnk_nxt.bitCnt = 4'h0;
              lnk_nxt.st = LS_ACK;
              lnk_nxt.sdaOe = 1'b1;
              if (lnk_r.st == LS_ADDR) begin
                lnk_nxt.rw = lnk_r.shift[0];
                if (lnk_r.shift[7:1] != `PMW_DEV_ADDR) begin
                  lnk_nxt.st = LS_SKIP;
                  lnk_nxt.sdaOe = 1'b0;
                end else if (lnk_r.shift[0] == `PMW_RW_READ) begin
                  lnk_nxt.reqTgl = ~lnk_r.reqTgl;
                  lnk_nxt.reqIdx = `PMW_IDX_CMD;
                  lnk_nxt.txIdx = `PMW_IDX_CMD;
                  lnk_nxt.isBlock = 1'b0;
                  lnk_nxt.pend = 1'b1;
                end else begin
                  lnk_nxt.rxIdx = `PMW_IDX_CMD;
                end
              end else begin
                lnk_nxt.rxIdx = lnk_r.rxIdx + 8'h01;
                if (lnk_r.rxIdx == `PMW_IDX_CMD) begin
                  lnk_nxt.cmd = lnk_r.shift;
                  lnk_nxt.cmdTgl = ~lnk_r.cmdTgl;
                end else if (lnk_r.rxIdx == `PMW_IDX_LO) begin
                  lnk_nxt.wrLo = lnk_r.shift;
                end else if (lnk_r.rxIdx == `PMW_IDX_HI) begin
                  lnk_nxt.wrWord = {lnk_r.shift, lnk_r.wrLo};
                  lnk_nxt.wrTgl = ~lnk_r.wrTgl;
                end else begin
                  // Too many bytes for a word: refuse them.
                  lnk_nxt.st = LS_SKIP;
                  lnk_nxt.sdaOe = 1'b0;
                end
              end
            end
          end
          LS_ACK: begin
            if (sclFall) begin
              lnk_nxt.sdaOe = 1'b0;
              lnk_nxt.st = lnk_r.rw ? LS_LOAD : LS_RX;
            end
          end
          LS_LOAD: begin
            // The clock is stretched until the answer has crossed over;
            // the host cannot outrun a slow fetch.
            if (!lnk_r.pend) begin
              lnk_nxt.sdaOe = ~txByte[7];
              lnk_nxt.shift = {txByte[6:0], 1'b0};
              lnk_nxt.bitCnt = 4'h0;
              lnk_nxt.sclOe = 1'b0;
              lnk_nxt.st = LS_TX;
            end else begin
              lnk_nxt.sclOe = 1'b1;
            end
          end
          LS_TX: begin
            if (sclRise) begin
              lnk_nxt.bitCnt = lnk_r.bitCnt + 4'h1;
            end else if (sclFall) begin
              if (lnk_r.bitCnt == `PMW_BITS_PER_BYTE) begin
                lnk_nxt.sdaOe = 1'b0;
                lnk_nxt.st = LS_TXACK;
              end else begin
                lnk_nxt.sdaOe = ~lnk_r.shift[7];
                lnk_nxt.shift = {lnk_r.shift[6:0], 1'b0};
              end
            end
          end
          LS_TXACK: begin
            if (sclRise) begin
              if (!lnk_r.sdaS2) begin
                lnk_nxt.txIdx = lnk_r.txIdx + 8'h01;
                if (lnk_r.isBlock && lnk_r.txIdx < lnk_r.count) begin
                  lnk_nxt.reqTgl = ~lnk_r.reqTgl;
                  lnk_nxt.reqIdx = lnk_r.txIdx + 8'h01;
                  lnk_nxt.pend = 1'b1;
                end
              end else begin
                lnk_nxt.st = LS_SKIP;
              end
            end else if (sclFall) begin
              lnk_nxt.st = LS_LOAD;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge linkClk) begin
    lnk_r <= lnk_nxt;
  end

  // =====================================================================
  // System-side handshake and decode
  pmw_lin11_decode u_decode (
    .word(lnk_r.wrWord),
    .expo(decExpo),
    .mant(decMant),
    .value(decValue)
  );

  always_comb begin
    sys_nxt = sys_r;
    sys_nxt.reqS1 = lnk_r.reqTgl;
    sys_nxt.reqS2 = sys_r.reqS1;
    sys_nxt.reqP = sys_r.reqS2;
    sys_nxt.cmdS1 = lnk_r.cmdTgl;
    sys_nxt.cmdS2 = sys_r.cmdS1;
    sys_nxt.cmdP = sys_r.cmdS2;
    sys_nxt.wrS1 = lnk_r.wrTgl;
    sys_nxt.wrS2 = sys_r.wrS1;
    sys_nxt.wrP = sys_r.wrS2;
    sys_nxt.fetchReq = 1'b0;
    sys_nxt.cmdStrobe = 1'b0;
    sys_nxt.wrStrobe = 1'b0;
    if (!rst_n) begin
      sys_nxt = '0;
    end else begin
      if (sys_r.reqS2 ^ sys_r.reqP) begin
        sys_nxt.fetchReq = 1'b1;
        sys_nxt.fetchIdx = lnk_r.reqIdx;
        sys_nxt.waitRsp = 1'b1;
      end else if (sys_r.waitRsp && rspValid) begin
        sys_nxt.rspHeld = rsp;
        sys_nxt.ackTgl = ~sys_r.ackTgl;
        sys_nxt.waitRsp = 1'b0;
      end
      if (sys_r.cmdS2 ^ sys_r.cmdP) begin
        sys_nxt.cmdStrobe = 1'b1;
        sys_nxt.cmdCode = lnk_r.cmd;
      end
      if (sys_r.wrS2 ^ sys_r.wrP) begin
        sys_nxt.wrStrobe = 1'b1;
        sys_nxt.wr = '{cmd: lnk_r.cmd, word: lnk_r.wrWord, expo: decExpo,
                       mant: decMant, value: decValue};
      end
    end
  end

  always_ff @(posedge clk) begin
    sys_r <= sys_nxt;
  end

  assign sclOut = lnk_r.lowOut;
  assign sdaOut = lnk_r.lowOut;
  assign sclOe = lnk_r.sclOe;
  assign sdaOe = lnk_r.sdaOe;
  assign fetchReq = sys_r.fetchReq;
  assign fetchIdx = sys_r.fetchIdx;
  assign cmdStrobe = sys_r.cmdStrobe;
  assign cmdCode = sys_r.cmdCode;
  assign wrStrobe = sys_r.wrStrobe;
  assign wr = sys_r.wr;

  // =====================================================================
  // Checks
  addr_ack_a: assert property (@(posedge linkClk) disable iff (!lnk_r.rstS2)
    (lnk_r.st == LS_ACK) |-> lnk_r.sdaOe)
    else $error("acknowledge slot not driven low");
  read_turn_a: assert property (@(posedge linkClk) disable iff (!lnk_r.rstS2)
    (lnk_r.st == LS_ACK && lnk_r.rw && sclFall && !startSeen && !stopSeen)
      |=> (lnk_r.st == LS_LOAD && !lnk_r.sdaOe))
    else $error("read acknowledge did not turn to sending");
  stretch_only_a: assert property (@(posedge linkClk) disable iff (!lnk_r.rstS2)
    lnk_r.sclOe |-> ((lnk_r.pend || $past(lnk_r.pend)) && lnk_r.st == LS_LOAD))
    else $error("clock held without a pending fetch");
  high_second_a: assert property (@(posedge linkClk) disable iff (!lnk_r.rstS2)
    (lnk_r.st == LS_LOAD && !lnk_r.pend && !lnk_r.isBlock && lnk_r.txIdx == 8'h01
      && !startSeen && !stopSeen && !ackEvt) |=> (lnk_r.sdaOe == ~lnk_r.txWord[15]))
    else $error("second word byte is not the high byte");
  word_len_a: assert property (@(posedge linkClk) disable iff (!lnk_r.rstS2)
    (lnk_r.st == LS_TX && !lnk_r.isBlock && lnk_r.txIdx > 8'h01) |-> !lnk_r.sdaOe)
    else $error("word read sent more than two bytes");
  nack_end_a: assert property (@(posedge linkClk) disable iff (!lnk_r.rstS2)
    (lnk_r.st == LS_TXACK && sclRise && lnk_r.sdaS2 && !startSeen && !stopSeen)
      |=> lnk_r.st == LS_SKIP ##1 !lnk_r.sdaOe)
    else $error("host NACK did not end sending");
  block_count_a: assert property (@(posedge linkClk) disable iff (!lnk_r.rstS2)
    (lnk_r.st == LS_LOAD && !lnk_r.pend && lnk_r.isBlock && lnk_r.txIdx == 8'h00
      && !startSeen && !stopSeen) |=> (lnk_r.sdaOe == ~lnk_r.count[7]))
    else $error("block read did not open with the count");
  lin_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
    sys_r.wrStrobe |-> (sys_r.wr.expo == $signed(sys_r.wr.word[15:11])
      && sys_r.wr.mant == $signed(sys_r.wr.word[10:0])))
    else $error("linear-11 fields split wrongly");
  lin_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    (sys_r.wrStrobe && sys_r.wr.mant != 11'sh000)
      |-> (sys_r.wr.value != 48'sh0 && sys_r.wr.value[47] == sys_r.wr.mant[10]))
    else $error("decoded value lost magnitude or sign");
  fetch_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    sys_r.fetchReq |=> (!sys_r.fetchReq && sys_r.waitRsp))
    else $error("fetch request not a single pulse");

endmodule : pmw_secondary

`default_nettype wire

// ### test/pmw_host_model.sv
// Bus host model that drives the two-wire link of the secondary engine.
`timescale 1ns/1ps
`default_nettype none

module pmw_host_model (
  input wire logic linkClk,
  input wire logic scl,
  input wire logic sda,
  output logic sclLow,
  output logic sdaLow,
  output logic errFlag
);
  // ====================================================================
  // Bit timing
  // Each phase lasts 8 link periods, twice the minimum.
  // The secondary answers 3-4 periods after a fall, so that answer lands well inside it.
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    errFlag = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge linkClk);
    #1;
  endtask : wt
  // Releasing the clock line waits while the secondary stretches it.
  task automatic sclRelease();
    sclLow = 1'b0;
    do @(posedge linkClk); while (scl !== 1'b1);
    #1;
  endtask : sclRelease
  // Data changes 2 periods after the clock falls.
  // Without that hold the synchronisers could read a false start or stop.
  task automatic sclFall();
    sclLow = 1'b1;
    wt(2);
  endtask : sclFall
  // ====================================================================
  // Framing
  task automatic start();
    sdaLow = 1'b0;
    wt(8);
    sclRelease();
    wt(8);
    sdaLow = 1'b1;
    wt(8);
    sclFall();
  endtask : start
  task automatic bitCycle(input logic b, output logic s);
    sdaLow = ~b;
    wt(8);
    sclRelease();
    wt(8);
    s = sda;
    sclFall();
  endtask : bitCycle
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(b[i], s);
    bitCycle(1'b1, s);
    ack = ~s;
    if (!ack) errFlag = 1'b1;
  endtask : wrByte
  task automatic rdByte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(1'b1, b[i]);
    bitCycle(~ack, s);
  endtask : rdByte
  task automatic stop();
    sdaLow = 1'b1;
    wt(8);
    sclRelease();
    wt(8);
    sdaLow = 1'b0;
    wt(8);
  endtask : stop
endmodule : pmw_host_model

`default_nettype wire

// ### test/tb_pmbus_word_block_linear11.sv
// Self-checking bench for the PMBus secondary engine.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defines.svh"

module tb_pmbus_word_block_linear11 import pmw_pkg::*;;
  logic clk, linkClk, rst_n, rspValid, blkMode, sawStretch;
  logic sclOut, sclOe, sdaOut, sdaOe, fetchReq, cmdStrobe, wrStrobe;
  logic hSclLow, hSdaLow, hErr, sclW, sdaW;
  logic [7:0] fetchIdx, cmdCode, lastCmd, blkCnt;
  logic [15:0] wordVal;
  pmw_rsp_type rsp;
  pmw_wr_type wr, lastWr;
  int rspDelay, nCmd = 0, nWr = 0, cycles = 0, badCount = 0, nCompared = 0;

  // Pulled-up wires: low while any party pulls.
  assign sclW = ~((sclOe & ~sclOut) | hSclLow);
  assign sdaW = ~((sdaOe & ~sdaOut) | hSdaLow);

  pmw_secondary dut (.clk(clk), .rst_n(rst_n), .linkClk(linkClk), .sclIn(sclW),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .fetchReq(fetchReq), .fetchIdx(fetchIdx), .rspValid(rspValid), .rsp(rsp),
    .cmdStrobe(cmdStrobe), .cmdCode(cmdCode), .wrStrobe(wrStrobe), .wr(wr));
  pmw_host_model host (.linkClk(linkClk), .scl(sclW), .sda(sdaW), .sclLow(hSclLow),
    .sdaLow(hSdaLow), .errFlag(hErr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #37;
    forever #62.5 linkClk = ~linkClk;
  end

  // ====================================================================
  // User side answering fetches
  initial begin
    logic [7:0] idx;
    rspValid = 1'b0;
    rsp = '0;
    forever begin
      @(posedge clk);
      #1;
      if (fetchReq === 1'b1) begin
        idx = fetchIdx;
        repeat (rspDelay) @(posedge clk);
        @(posedge clk);
        #1;
        rspValid = 1'b1;
        if (idx == 8'h00) rsp = blkMode ? '{1'b1, {8'h00, blkCnt}} : '{1'b0, wordVal};
        else rsp = '{1'b0, {8'h00, 8'h10 + idx}};
        @(posedge clk);
        #1;
        rspValid = 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (cmdStrobe === 1'b1) begin
      nCmd <= nCmd + 1;
      lastCmd <= cmdCode;
    end
    if (wrStrobe === 1'b1) begin
      nWr <= nWr + 1;
      lastWr <= wr;
    end
    if (sclOe === 1'b1) sawStretch <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      badCount = badCount + 1;
      stopTest();
    end
  end

  // ====================================================================
  // Checks and bus steps
  task automatic chkVal(input logic [47:0] got, input logic [47:0] exp, input string what);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chkVal
  task automatic chkBit(input logic got, input logic exp, input string what);
    chkVal({47'h0, got}, {47'h0, exp}, what);
  endtask : chkBit
  task automatic stopTest();
    $display("compared %0d, wrong %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stopTest
  task automatic sendByte(input logic [7:0] b, input logic exp, input string what);
    logic a;
    host.wrByte(b, a);
    chkBit(a, exp, what);
  endtask : sendByte
  task automatic recvByte(input logic ack, input logic [7:0] exp, input string what);
    logic [7:0] b;
    host.rdByte(ack, b);
    chkVal({40'h0, b}, {40'h0, exp}, what);
  endtask : recvByte
  task automatic openCmd(input logic [7:0] c);
    int n0;
    n0 = nCmd;
    host.start();
    sendByte({`PMW_DEV_ADDR, 1'b0}, 1'b1, "address ack");
    sendByte(c, 1'b1, "command ack");
    chkVal({40'h0, lastCmd}, {40'h0, c}, "command code");
    chkVal(48'(nCmd), 48'(n0 + 1), "command count");
  endtask : openCmd

  // ====================================================================
  // Scenarios
  task automatic testWrites();
    logic [15:0] w [4];
    logic [47:0] v [4];
    w = '{16'hd280, 16'he085, 16'h7c00, 16'h8001};
    v = '{48'h0a0000, 48'h085000, 48'hfe0000000000, 48'h000000000001};
    for (int i = 0; i < 4; i++) begin
      openCmd(8'h20 + 8'(i));
      sendByte(w[i][7:0], 1'b1, "low ack");
      sendByte(w[i][15:8], 1'b1, "high ack");
      if (i == 3) sendByte(8'h55, 1'b0, "extra byte nack");
      host.stop();
      chkVal({32'h0, lastWr.word}, {32'h0, w[i]}, "write word");
      chkVal({40'h0, lastWr.cmd}, {40'h0, 8'h20 + 8'(i)}, "write command");
      chkVal({43'h0, lastWr.expo}, {43'h0, w[i][15:11]}, "exponent");
      chkVal({37'h0, lastWr.mant}, {37'h0, w[i][10:0]}, "mantissa");
      chkVal(lastWr.value, v[i], "scaled value");
      chkVal(48'(nWr), 48'(i + 1), "write count");
    end
    chkBit(hErr, 1'b1, "sticky error");
  endtask : testWrites
  task automatic testWordRead();
    blkMode = 1'b0;
    wordVal = 16'hb2c1;
    rspDelay = 0;
    openCmd(8'h79);
    host.start();
    sendByte({`PMW_DEV_ADDR, `PMW_RW_READ}, 1'b1, "read address ack");
    recvByte(1'b1, 8'hc1, "low byte");
    recvByte(1'b0, 8'hb2, "high byte");
    host.stop();
  endtask : testWordRead
  task automatic testBlockRead();
    blkMode = 1'b1;
    blkCnt = 8'h03;
    rspDelay = 150;
    sawStretch = 1'b0;
    openCmd(8'h9e);
    host.start();
    sendByte({`PMW_DEV_ADDR, `PMW_RW_READ}, 1'b1, "read address ack");
    recvByte(1'b1, 8'h03, "byte count");
    for (int n = 1; n <= 3; n++) recvByte(n < 3, 8'h10 + 8'(n), "block data");
    host.stop();
    chkBit(sawStretch, 1'b1, "clock stretched");
  endtask : testBlockRead
  task automatic testBadAddr();
    int n0;
    n0 = nCmd;
    host.start();
    sendByte({7'h5b, 1'b0}, 1'b0, "foreign address nack");
    host.stop();
    chkVal(48'(nCmd), 48'(n0), "no command taken");
  endtask : testBadAddr

  // Reset is held 30 cycles so the slower link side sees it through its synchroniser.
  initial begin
    rst_n = 1'b0;
    blkMode = 1'b0;
    blkCnt = 8'h00;
    wordVal = 16'h0000;
    rspDelay = 0;
    sawStretch = 1'b0;
    repeat (30) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (40) @(posedge clk);
    chkBit(sclOe | sdaOe, 1'b0, "idle release");
    chkBit(sclOut | sdaOut, 1'b0, "open drain level");
    testWrites();
    testWordRead();
    testBlockRead();
    testBadAddr();
    stopTest();
  end
endmodule : tb_pmbus_word_block_linear11

`default_nettype wire
